// file: dv/cpu_stack_and_interrupt_control_tb.sv
// Purpose: self-checking bench for the stack and interrupt control core
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   strobes drop for one cycle between transfers
module cpu_stack_and_interrupt_control_tb import core_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 0, rstn_i = 0, io_we_i = 0, io_re_i = 0, instr_done_i = 0, sei_i = 0, cli_i = 0;
    logic        sleep_i = 0, reset_vector_fuse_i = 0, reg_we_i = 0, ptr_go_i = 0;
    logic        stall_o, irq_ack_o, vector_valid_o, pc_load_o, stack_we_o, stack_re_o;
    logic [5:0]  io_addr_i = 0, disp_i = 0;
    logic [7:0]  io_wdata_i = 0, reg_wdata_i = 0, irq_event_i = 0, irq_level_i = 0;
    logic [7:0]  io_rdata_o, stack_rdata_i, stack_wdata_o;
    logic [15:0] pc_i = 0, data_addr_o, stack_addr_o, vector_o, pc_o, reset_vector_o;
    logic [2:0]  reg_idx_i = 0;
    logic [1:0]  ptr_sel_i = 2'h2;
    sp_op_t      sp_op_i = SP_NONE;
    addr_mode_t  ptr_mode_i = AM_PLAIN;
    int          fails = 0, cmp_count = 0, i;
    sp_op_t      ops [4] = '{SP_PUSH1, SP_CALL, SP_POP1, SP_RET};
    logic [7:0]  spx [4] = '{8'h7F, 8'h7D, 8'h7E, 8'h80};

    // top source made level type so the level request path is reachable
    cpu_stack_irq_ctrl #(.LEVEL_MASK(8'h80)) DUT (.*);
    stack_mem_model mem (.ref_clk_i(ref_clk_i), .addr_i(stack_addr_o), .wdata_i(stack_wdata_o),
        .we_i(stack_we_o), .re_i(stack_re_o), .rdata_o(stack_rdata_i));

    initial forever #2.5 ref_clk_i = ~ref_clk_i;

    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        io_addr_i = a;
        io_wdata_i = d;
        io_we_i = 1;
        step;
        io_we_i = 0;
        step;
    endtask
    task automatic io_rd(input logic [5:0] a, input logic [7:0] e, input string n);
        io_addr_i = a;
        io_re_i = 1;
        step;
        io_re_i = 0;
        step;
        chk(n, {8'h00, e}, {8'h00, io_rdata_o});
    endtask
    task automatic regw(input logic [2:0] x, input logic [7:0] d);
        reg_idx_i = x;
        reg_wdata_i = d;
        reg_we_i = 1;
        step;
        reg_we_i = 0;
        step;
    endtask
    task automatic ptr(input addr_mode_t m, input logic [5:0] d, input logic [15:0] e);
        ptr_mode_i = m;
        disp_i = d;
        ptr_go_i = 1;
        step;
        ptr_go_i = 0;
        step;
        chk("ptr", e, data_addr_o);
    endtask
    // one instruction boundary, then the acknowledge it must or must not give
    task automatic boundary(input logic e, input string n);
        instr_done_i = 1;
        step;
        instr_done_i = 0;
        chk(n, {15'h0000, e}, {15'h0000, irq_ack_o});
    endtask
    // bounded wait on vector_valid_o (w 0) or pc_load_o (w 1), cycles taken in i
    task automatic wait_hi(input bit w);
        i = 0;
        while ((w ? pc_load_o : vector_valid_o) !== 1'b1 && i < 20)
        begin
            step;
            i++;
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #5000;
        fails++;
        give_verdict;
    end

    initial
    begin
        repeat (8) step;
        rstn_i = 1;
        step;
        chk("rst_vec", 16'h0000, reset_vector_o);
        io_rd(IO_SPH, SRAM_LAST_RST[15:8], "sp_hi");
        io_rd(IO_SPL, SRAM_LAST_RST[7:0], "sp_lo");
        io_wr(IO_SPL, 8'h80);
        io_wr(IO_SPH, 8'h02);
        io_rd(IO_SPH, 8'h02, "sp_hi");
        io_rd(6'h00, 8'h00, "unmapped");
        for (i = 0; i < 4; i++)
        begin
            sp_op_i = ops[i];
            step;
            sp_op_i = SP_NONE;
            io_rd(IO_SPL, spx[i], "sp_lo");
        end
        regw(3'h4, 8'h00);
        regw(3'h5, 8'h01);
        ptr(AM_PREDEC, 6'h00, 16'h00FF);
        ptr(AM_DISP, 6'h03, 16'h0102);
        regw(3'h0, 8'h10);
        regw(3'h1, 8'h02);
        ptr_sel_i = 2'h0;
        ptr(AM_POSTINC, 6'h00, 16'h0210);
        ptr(AM_PLAIN, 6'h00, 16'h0211);
        io_wr(IO_IRQ_EN, 8'h03);
        irq_event_i = 8'h03;
        step;
        irq_event_i = 8'h00;
        io_rd(IO_IRQ_FLAG, 8'h03, "flags");
        pc_i = 16'h1234;
        sei_i = 1;
        instr_done_i = 1;
        step;
        sei_i = 0;
        chk("ack_sei", 16'h0000, {15'h0000, irq_ack_o});
        step;
        instr_done_i = 0;
        chk("ack", 16'h0001, {15'h0000, irq_ack_o});
        wait_hi(1'b0);
        chk("entry_len", 16'h0004, 16'(i));
        chk("vector", 16'h0002, vector_o);
        io_rd(IO_SPL, 8'h7E, "sp_lo");
        io_rd(IO_STATUS_REGISTER, 8'h00, "status");
        io_rd(IO_IRQ_FLAG, 8'h02, "flags");
        sp_op_i = SP_RETURN_FROM_INTERRUPT;
        step;
        sp_op_i = SP_NONE;
        wait_hi(1'b1);
        chk("return_from_interrupt_len", 16'h0004, 16'(i));
        chk("pc", 16'h1234, pc_o);
        io_rd(IO_SPL, 8'h80, "sp_lo");
        io_rd(IO_STATUS_REGISTER, 8'h80, "status");
        instr_done_i = 1;
        step;
        instr_done_i = 0;
        chk("ack2", 16'h0001, {15'h0000, irq_ack_o});
        wait_hi(1'b0);
        chk("vector2", 16'h0004, vector_o);
        // events on disabled sources still flag; write one clears, zero keeps
        irq_event_i = 8'h0C;
        step;
        irq_event_i = 8'h00;
        io_rd(IO_IRQ_FLAG, 8'h0C, "flags_off");
        io_wr(IO_IRQ_FLAG, 8'h04);
        io_rd(IO_IRQ_FLAG, 8'h08, "flags_w1c");
        io_wr(IO_CORE_CTRL, 8'h02);
        io_rd(IO_CORE_CTRL, 8'h02, "vsel");
        io_wr(IO_IRQ_EN, 8'h08);
        io_wr(IO_STATUS_REGISTER, 8'h80);
        sleep_i = 1;
        boundary(1'b1, "ack_sleep");
        sleep_i = 0;
        chk("stall", 16'h0001, {15'h0000, stall_o});
        wait_hi(1'b0);
        chk("sleep_len", 16'h0008, 16'(i));
        chk("vector3", BOOT_START_RST + 16'h0008, vector_o);
        // pending flag must not slip past the clear-enable boundary
        io_wr(IO_STATUS_REGISTER, 8'h80);
        irq_event_i = 8'h08;
        step;
        irq_event_i = 8'h00;
        cli_i = 1;
        boundary(1'b0, "ack_cli");
        cli_i = 0;
        boundary(1'b0, "ack_after_cli");
        // level condition gone before enabling leaves nothing behind
        irq_level_i = 8'h80;
        step;
        irq_level_i = 8'h00;
        io_wr(IO_IRQ_EN, 8'h80);
        io_rd(IO_IRQ_FLAG, 8'h08, "flags_lvl");
        io_wr(IO_STATUS_REGISTER, 8'h80);
        boundary(1'b0, "ack_lvl_gone");
        irq_level_i = 8'h80;
        boundary(1'b1, "ack_lvl");
        wait_hi(1'b0);
        chk("vector4", BOOT_START_RST + 16'h0010, vector_o);
        irq_level_i = 8'h00;
        reset_vector_fuse_i = 1;
        step;
        chk("boot_vec", BOOT_START_RST, reset_vector_o);
        // second reset in mid-run
        rstn_i = 0;
        step;
        rstn_i = 1;
        step;
        chk("boot_vec_rst", BOOT_START_RST, reset_vector_o);
        io_rd(IO_SPH, SRAM_LAST_RST[15:8], "sp_hi_rst");
        io_rd(IO_STATUS_REGISTER, 8'h00, "status_rst");
        give_verdict;
    end
endmodule

// file: dv/stack_mem_model.sv
// Purpose: stack memory standing beside the control core
// Assumes: synchronous byte memory on the core clock
// Notes:   read data one cycle after the read strobe
module stack_mem_model
(
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial rdata_o = 8'h00;
    always @(posedge ref_clk_i)
    begin
        if (we_i)
            mem[addr_i] <= wdata_i;
        // no read: flip, so a stale byte never looks valid
        rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
    end
endmodule

// file: inc/core_ctrl_pkg.sv
// Purpose: shared constants and types for the stack and interrupt control core
// Assumes: 6-bit I/O space addresses, 16-bit data space
// Notes:   offsets are I/O addresses, not data space addresses
package core_ctrl_pkg;

    // I/O space map
    localparam logic [5:0]  IO_SPL       = 6'h3D;
    localparam logic [5:0]  IO_SPH       = 6'h3E;
    localparam logic [5:0]  IO_STATUS_REGISTER      = 6'h3F;
    localparam logic [5:0]  IO_CORE_CTRL = 6'h35;
    localparam logic [5:0]  IO_IRQ_EN    = 6'h30;
    localparam logic [5:0]  IO_IRQ_FLAG  = 6'h31;

    // field positions
    localparam int          GIE_BIT      = 7;
    localparam int          VSEL_BIT     = 1;

    // values after reset
    localparam logic [15:0] SRAM_LAST_RST  = 16'h04FF;
    localparam logic [15:0] BOOT_START_RST = 16'h1C00;

    // cycle counts
    localparam logic [3:0]  ENTRY_CYCLES = 4'h4;
    localparam logic [3:0]  SLEEP_EXTRA  = 4'h4;
    localparam logic [3:0]  RETURN_FROM_INTERRUPT_CYCLES  = 4'h4;

    // vector slot size in program words
    localparam logic [15:0] VEC_STRIDE   = 16'h0002;

    typedef enum logic [2:0] {
        SP_NONE  = 3'b000,
        SP_PUSH1 = 3'b001,
        SP_POP1  = 3'b010,
        SP_CALL  = 3'b011,
        SP_RET   = 3'b100,
        SP_RETURN_FROM_INTERRUPT  = 3'b101
    } sp_op_t;

    typedef enum logic [1:0] {
        AM_PLAIN   = 2'b00,
        AM_DISP    = 2'b01,
        AM_POSTINC = 2'b10,
        AM_PREDEC  = 2'b11
    } addr_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ENTRY = 2'b01,
        ST_RETURN_FROM_INTERRUPT  = 2'b10
    } ctrl_state_t;

endpackage

// file: inc/irq_if.sv
// Purpose: carrier between the control core and the interrupt arbiter
// Assumes: one clock domain
// Notes:   ctrl side drives sources, enables and clears; arb side answers
interface irq_if #(parameter int N = 8);
    logic [N-1:0]         ev;
    logic [N-1:0]         lvl;
    logic [N-1:0]         en;
    logic [N-1:0]         w1c;
    logic [N-1:0]         flags;
    logic [N-1:0]         pending;
    logic                 take;
    logic [$clog2(N)-1:0] take_idx;
    logic [$clog2(N)-1:0] win_idx;

    modport ctrl (output ev, lvl, en, w1c, take, take_idx,
                  input  flags, pending, win_idx);
    modport arb  (input  ev, lvl, en, w1c, take, take_idx,
                  output flags, pending, win_idx);
endinterface

// file: rtl/cpu_stack_irq_ctrl.sv
// Purpose: pointer pairs, stack pointer and interrupt entry/exit control
// Assumes: sequencer marks instruction ends, sync stack memory, one clock
// Notes:   stack memory returns read data one cycle after stack_re_o
module cpu_stack_irq_ctrl
    import core_ctrl_pkg::*;
#(
    parameter int                 NUM_IRQ    = 8,
    parameter logic [NUM_IRQ-1:0] LEVEL_MASK = '0,
    parameter logic [15:0]        LAST_SRAM  = SRAM_LAST_RST,
    parameter logic [15:0]        BOOT_START = BOOT_START_RST
)
(
    input  wire logic               ref_clk_i,
    input  wire logic               rstn_i,
    input  wire logic [5:0]         io_addr_i,
    input  wire logic [7:0]         io_wdata_i,
    input  wire logic               io_we_i,
    input  wire logic               io_re_i,
    output logic      [7:0]         io_rdata_o,
    input  wire sp_op_t             sp_op_i,
    input  wire logic               instr_done_i,
    input  wire logic               sei_i,
    input  wire logic               cli_i,
    input  wire logic               sleep_i,
    input  wire logic [15:0]        pc_i,
    input  wire logic               reset_vector_fuse_i,
    input  wire logic [NUM_IRQ-1:0] irq_event_i,
    input  wire logic [NUM_IRQ-1:0] irq_level_i,
    input  wire logic               reg_we_i,
    input  wire logic [2:0]         reg_idx_i,
    input  wire logic [7:0]         reg_wdata_i,
    input  wire logic               ptr_go_i,
    input  wire logic [1:0]         ptr_sel_i,
    input  wire addr_mode_t         ptr_mode_i,
    input  wire logic [5:0]         disp_i,
    input  wire logic [7:0]         stack_rdata_i,
    output logic      [15:0]        data_addr_o,
    output logic      [15:0]        stack_addr_o,
    output logic      [7:0]         stack_wdata_o,
    output logic                    stack_we_o,
    output logic                    stack_re_o,
    output logic                    stall_o,
    output logic                    irq_ack_o,
    output logic                    vector_valid_o,
    output logic      [15:0]        vector_o,
    output logic                    pc_load_o,
    output logic      [15:0]        pc_o,
    output logic      [15:0]        reset_vector_o
);

    irq_if #(.N(NUM_IRQ)) a ();

    ctrl_state_t  state;
    ctrl_state_t  next_state;
    logic [3:0]   cnt;
    logic [3:0]   next_cnt;
    logic [3:0]   last;
    logic [3:0]   next_last;
    logic [15:0]  stack_pointer;
    logic [15:0]  next_stack_pointer;
    logic         gie;
    logic         next_gie;
    logic         vsel;
    logic         next_vsel;
    logic [NUM_IRQ-1:0] en;
    logic [NUM_IRQ-1:0] next_en;
    logic [15:0]  next_pc;
    logic [15:0]  next_vector;
    logic [15:0]  next_reset_vector;
    logic [7:0]   next_rdata;
    logic [15:0]  next_stack_addr;
    logic [7:0]   next_stack_wdata;
    logic         next_stack_we;
    logic         next_stack_re;
    logic         next_stall;
    logic         next_vector_valid;
    logic         next_pc_load;
    logic         take_now;
    logic [15:0]  vec_base;
    logic [15:0]  ptr [3];
    logic [15:0]  next_ptr [3];
    logic [15:0]  next_data_addr;
    logic [15:0]  base;

    irq_arbiter #(
        .N          (NUM_IRQ),
        .LEVEL_MASK (LEVEL_MASK)
    ) u_arb (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .bus       (a.arb)
    );

    assign a.ev       = irq_event_i;
    assign a.lvl      = irq_level_i;
    assign a.en       = en;
    assign a.take     = take_now;
    assign a.take_idx = a.win_idx;

    // decided at the instruction end while the next fetch is already underway;
    // return_from_interrupt, sei and cli boundaries never vector
    assign take_now = (state == ST_IDLE) && instr_done_i && gie && (|a.pending)
                      && !cli_i
                      && !sei_i
                      && (sp_op_i != SP_RETURN_FROM_INTERRUPT);

    assign vec_base = vsel ? BOOT_START : 16'h0000;

    always_comb
    begin
        next_state        = state;
        next_cnt          = cnt;
        next_last         = last;
        next_stack_pointer = stack_pointer;
        next_gie          = gie;
        next_vsel         = vsel;
        next_en           = en;
        next_pc           = pc_o;
        next_vector       = vector_o;
        next_rdata        = io_rdata_o;
        next_stack_addr   = stack_addr_o;
        next_stack_wdata  = stack_wdata_o;
        next_stack_we     = 1'b0;
        next_stack_re     = 1'b0;
        next_vector_valid = 1'b0;
        next_pc_load      = 1'b0;
        next_reset_vector = reset_vector_fuse_i ? BOOT_START : 16'h0000;
        a.w1c             = '0;
        if (io_re_i)
        begin
            case (io_addr_i)
                IO_SPL:       next_rdata = stack_pointer[7:0];
                IO_SPH:       next_rdata = stack_pointer[15:8];
                IO_STATUS_REGISTER:      next_rdata = {gie, 7'h00};
                IO_CORE_CTRL: next_rdata = 8'(vsel) << VSEL_BIT;
                IO_IRQ_EN:    next_rdata = 8'(en);
                IO_IRQ_FLAG:  next_rdata = 8'(a.flags);
                default:      next_rdata = 8'h00;
            endcase
        end
        if (io_we_i)
        begin
            case (io_addr_i)
                IO_SPL:       next_stack_pointer[7:0]  = io_wdata_i;
                IO_SPH:       next_stack_pointer[15:8] = io_wdata_i;
                IO_STATUS_REGISTER:      next_gie  = io_wdata_i[GIE_BIT];
                IO_CORE_CTRL: next_vsel = io_wdata_i[VSEL_BIT];
                IO_IRQ_EN:    next_en   = io_wdata_i[NUM_IRQ-1:0];
                IO_IRQ_FLAG:  a.w1c     = io_wdata_i[NUM_IRQ-1:0];
                default:      ;
            endcase
        end
        if (cli_i)
            next_gie = 1'b0;
        else if (sei_i)
            next_gie = 1'b1;
        unique case (state)
            ST_IDLE:
            begin
                if (take_now)
                begin
                    // only the enable bit moves; other status bits are software's job
                    next_gie          = 1'b0;
                    next_state        = ST_ENTRY;
                    next_cnt          = 4'h0;
                    next_last         = sleep_i ? ENTRY_CYCLES + SLEEP_EXTRA - 4'h1
                                                : ENTRY_CYCLES - 4'h1;
                    next_pc           = pc_i;
                    next_vector       = vec_base + VEC_STRIDE * (16'(a.win_idx) + 16'h0001);
                    next_stack_we     = 1'b1;
                    next_stack_addr   = stack_pointer;
                    next_stack_wdata  = pc_i[7:0];
                end
                else if (sp_op_i == SP_RETURN_FROM_INTERRUPT)
                begin
                    next_state        = ST_RETURN_FROM_INTERRUPT;
                    next_cnt          = 4'h0;
                    next_stack_re     = 1'b1;
                    next_stack_addr   = stack_pointer + 16'h0001;
                end
                else
                begin
                    case (sp_op_i)
                        SP_PUSH1: next_stack_pointer = stack_pointer - 16'h0001;
                        SP_POP1:  next_stack_pointer = stack_pointer + 16'h0001;
                        SP_CALL:  next_stack_pointer = stack_pointer - 16'h0002;
                        SP_RET:   next_stack_pointer = stack_pointer + 16'h0002;
                        default:  ;
                    endcase
                end
            end
            ST_ENTRY:
            begin
                next_cnt = cnt + 4'h1;
                if (cnt == 4'h0)
                begin
                    next_stack_we      = 1'b1;
                    next_stack_addr    = stack_pointer - 16'h0001;
                    next_stack_wdata   = pc_o[15:8];
                    next_stack_pointer = stack_pointer - 16'h0002;
                end
                if (cnt == last)
                begin
                    next_state        = ST_IDLE;
                    next_vector_valid = 1'b1;
                end
            end
            ST_RETURN_FROM_INTERRUPT:
            begin
                next_cnt = cnt + 4'h1;
                if (cnt == 4'h0)
                begin
                    next_stack_re   = 1'b1;
                    next_stack_addr = stack_pointer + 16'h0002;
                end
                if (cnt == 4'h1)
                    next_pc[15:8] = stack_rdata_i;
                if (cnt == 4'h2)
                    next_pc[7:0] = stack_rdata_i;
                if (cnt == RETURN_FROM_INTERRUPT_CYCLES - 4'h1)
                begin
                    next_state         = ST_IDLE;
                    next_stack_pointer = stack_pointer + 16'h0002;
                    next_gie           = 1'b1;
                    next_pc_load       = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_stall = (next_state != ST_IDLE);
    end

    // single clock straight from the chip source, no divider anywhere
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state          <= ST_IDLE;
            cnt            <= 4'h0;
            last           <= 4'h0;
            stack_pointer  <= LAST_SRAM;
            gie            <= 1'b0;
            vsel           <= 1'b0;
            en             <= '0;
            pc_o           <= 16'h0000;
            vector_o       <= 16'h0000;
            io_rdata_o     <= 8'h00;
            stack_addr_o   <= 16'h0000;
            stack_wdata_o  <= 8'h00;
            stack_we_o     <= 1'b0;
            stack_re_o     <= 1'b0;
            stall_o        <= 1'b0;
            irq_ack_o      <= 1'b0;
            vector_valid_o <= 1'b0;
            pc_load_o      <= 1'b0;
            reset_vector_o <= 16'h0000;
        end
        else
        begin
            state          <= next_state;
            cnt            <= next_cnt;
            last           <= next_last;
            stack_pointer  <= next_stack_pointer;
            gie            <= next_gie;
            vsel           <= next_vsel;
            en             <= next_en;
            pc_o           <= next_pc;
            vector_o       <= next_vector;
            io_rdata_o     <= next_rdata;
            stack_addr_o   <= next_stack_addr;
            stack_wdata_o  <= next_stack_wdata;
            stack_we_o     <= next_stack_we;
            stack_re_o     <= next_stack_re;
            stall_o        <= next_stall;
            irq_ack_o      <= take_now;
            vector_valid_o <= next_vector_valid;
            pc_load_o      <= next_pc_load;
            reset_vector_o <= next_reset_vector;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 3; i++)
            next_ptr[i] = ptr[i];
        next_data_addr = data_addr_o;
        base           = 16'h0000;
        if (reg_we_i && reg_idx_i < 3'd6)
        begin
            if (reg_idx_i[0])
                next_ptr[reg_idx_i[2:1]][15:8] = reg_wdata_i;
            else
                next_ptr[reg_idx_i[2:1]][7:0] = reg_wdata_i;
        end
        if (ptr_go_i && ptr_sel_i != 2'b11)
        begin
            base = ptr[ptr_sel_i];
            // pointer read, adjusted and written back inside the same cycle
            unique case (ptr_mode_i)
                AM_PLAIN:   next_data_addr = base;
                AM_DISP:    next_data_addr = base + {10'h000, disp_i};
                AM_POSTINC:
                begin
                    next_data_addr       = base;
                    next_ptr[ptr_sel_i]  = base + 16'h0001;
                end
                AM_PREDEC:
                begin
                    next_data_addr       = base - 16'h0001;
                    next_ptr[ptr_sel_i]  = base - 16'h0001;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < 3; i++)
                ptr[i] <= 16'h0000;
            data_addr_o <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                ptr[i] <= next_ptr[i];
            data_addr_o <= next_data_addr;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_entry_run;
        stall_o [*4] ##1 (vector_valid_o && !stall_o);
    endsequence

    sequence s_sleep_run;
        stall_o [*8] ##1 (vector_valid_o && !stall_o);
    endsequence

    sequence s_return_from_interrupt_start;
        (state == ST_IDLE) && (sp_op_i == SP_RETURN_FROM_INTERRUPT) && !io_we_i;
    endsequence

    a_cli_blocks: assert property (cli_i |=> !irq_ack_o)
        else $error("interrupt taken with clear-enable");
    a_sei_defers: assert property ((sei_i && instr_done_i) |=> !irq_ack_o)
        else $error("interrupt taken at set-enable boundary");
    a_return_from_interrupt_defers: assert property (s_return_from_interrupt_start |=> !irq_ack_o [*5])
        else $error("interrupt taken before one main instruction");
    a_entry_time: assert property ((take_now && !sleep_i) |=> s_entry_run)
        else $error("entry not four cycles");
    a_sleep_time: assert property ((take_now && sleep_i) |=> s_sleep_run)
        else $error("sleep entry not eight cycles");
    a_entry_sp: assert property ((take_now && !sleep_i && !io_we_i) |-> ##5 (stack_pointer == $past(stack_pointer, 5) - 16'h0002))
        else $error("entry did not lower stack pointer by two");
    a_entry_gie: assert property (take_now |=> (!gie && irq_ack_o))
        else $error("entry left global enable set");
    a_return_from_interrupt_end: assert property (s_return_from_interrupt_start |-> ##5 (pc_load_o && gie && stack_pointer == $past(stack_pointer, 5) + 16'h0002))
        else $error("return did not restore state in four cycles");
    a_push_one: assert property ((state == ST_IDLE && !take_now && !io_we_i && sp_op_i == SP_PUSH1) |=> (stack_pointer == $past(stack_pointer) - 16'h0001))
        else $error("push did not lower stack pointer by one");
    a_postinc: assert property ((ptr_go_i && ptr_mode_i == AM_POSTINC && ptr_sel_i == 2'b00 && !reg_we_i) |=> (data_addr_o == $past(ptr[0]) && ptr[0] == $past(ptr[0]) + 16'h0001))
        else $error("post-increment address or update wrong");

endmodule

// file: rtl/irq_arbiter.sv
// Purpose: interrupt flags, level sources and fixed priority selection
// Assumes: sources are on-chip logic on the core clock
// Notes:   index 0 sits right after the reset slot and wins over all others
module irq_arbiter
    import core_ctrl_pkg::*;
#(
    parameter int           N          = 8,
    parameter logic [N-1:0] LEVEL_MASK = '0
)
(
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    irq_if.arb        bus
);

    logic [N-1:0] flags;
    logic [N-1:0] next_flags;
    logic [N-1:0] take_mask;

    function automatic logic [$clog2(N)-1:0] first_set(input logic [N-1:0] v);
        logic [$clog2(N)-1:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
                idx = ($clog2(N))'(i);
        end
        return idx;
    endfunction

    always_comb
    begin
        take_mask  = bus.take ? (N'(1) << bus.take_idx) : '0;
        next_flags = flags & ~take_mask;
        next_flags = next_flags & ~bus.w1c;
        // a new event beats both clears in the same cycle
        next_flags = next_flags | (bus.ev & ~LEVEL_MASK);
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            flags <= '0;
        else
            flags <= next_flags;
    end

    // level sources carry no memory: gone before enabling means never taken
    assign bus.pending = ((flags & ~LEVEL_MASK) | (bus.lvl & LEVEL_MASK)) & bus.en;
    assign bus.win_idx = first_set(bus.pending);
    assign bus.flags   = flags;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_event_beats_clear: assert property ((bus.ev[0] && !LEVEL_MASK[0]) |=> flags[0])
        else $error("flag event lost against a clear");
    a_w1c_zero_keeps: assert property ((flags[0] && !bus.w1c[0] && !bus.take) |=> flags[0])
        else $error("flag dropped without a clear");
    a_w1c_one_clears: assert property ((bus.w1c[1] && !bus.ev[1] && !LEVEL_MASK[1]) |=> !flags[1])
        else $error("written one did not clear flag");
    a_take_clears: assert property ((bus.take && bus.take_idx == '0 && !bus.ev[0]) |=> !flags[0])
        else $error("served flag not cleared");
    a_lowest_wins: assert property ((bus.pending[0]) |-> (bus.win_idx == '0))
        else $error("lower vector lost priority");

endmodule
